// [src/cra_pkg.sv]
`default_nettype none
package cra_pkg;
  // =====================================================================
  // CPU-side special function register addresses
  localparam logic [7:0] SFR_STA    = 8'hC0;
  localparam logic [7:0] SFR_PTR    = 8'hC1;
  localparam logic [7:0] SFR_DAT    = 8'hC2;
  localparam logic [7:0] SFR_CON    = 8'hC3;
  localparam logic [7:0] SFR_MOD    = 8'hC4;
  // =====================================================================
  // Controller internal addresses
  localparam logic [7:0] IA_MODE    = 8'h00;
  localparam logic [7:0] IA_CMD     = 8'h01;
  localparam logic [7:0] IA_STAT    = 8'h02;
  localparam logic [7:0] IA_IRQ     = 8'h03;
  localparam logic [7:0] IA_IEN     = 8'h04;
  localparam logic [7:0] IA_RXIL    = 8'h05;
  localparam logic [7:0] IA_BT0     = 8'h06;
  localparam logic [7:0] IA_BT1     = 8'h07;
  localparam logic [7:0] IA_NOTE    = 8'h08;
  localparam logic [7:0] IA_RXSA    = 8'h0A;
  localparam logic [7:0] IA_EWL     = 8'h0D;
  localparam logic [7:0] IA_RXEC    = 8'h0E;
  localparam logic [7:0] IA_TXEC    = 8'h0F;
  localparam logic [7:0] IA_ACFM    = 8'h1D;
  localparam logic [7:0] IA_ACFE    = 8'h1E;
  localparam logic [7:0] IA_BANK_HI = 8'h3F;
  localparam logic [7:0] IA_RXW_LO  = 8'h60;
  localparam logic [7:0] IA_RXW_HI  = 8'h6C;
  localparam logic [7:0] IA_TXB_LO  = 8'h70;
  localparam logic [7:0] IA_TXB_HI  = 8'h7C;
  localparam logic [7:0] IA_FIFO_LO = 8'h80;
  localparam logic [7:0] AINC_MIN   = 8'h20;
  // =====================================================================
  // Sizes, reset values, fields
  localparam logic [3:0] TXB_LEN    = 4'hD;
  localparam int         FIFO_LEN   = 64;
  localparam logic [7:0] MODE_RST   = 8'h01;
  localparam int         MODE_RM    = 0;
  localparam logic [7:0] ZERO8      = 8'h00;

  typedef enum logic [2:0] {
    K_NONE, K_CORE, K_MODE, K_RXSA, K_RXWIN, K_TXB, K_FIFO
  } cra_kind_t;

  typedef enum logic {ST_IDLE, ST_ACCESS} cra_state_t;
endpackage
`default_nettype wire

// [src/cra_decode.sv]
`default_nettype none
module cra_decode import cra_pkg::*; (
  input  wire logic [7:0] i_addr,
  input  wire logic       i_reset_mode,
  output var cra_kind_t   o_rd_kind,
  output var cra_kind_t   o_wr_kind
);
  // =====================================================================
  // Read map
  always_comb begin
    o_rd_kind = K_NONE;
    if (i_addr >= IA_FIFO_LO) begin
      o_rd_kind = K_FIFO;
    end else if (i_addr >= IA_TXB_LO && i_addr <= IA_TXB_HI) begin
      o_rd_kind = K_TXB;
    end else if (i_addr >= IA_RXW_LO && i_addr <= IA_RXW_HI) begin
      o_rd_kind = K_RXWIN;
    end else if (i_addr >= IA_ACFM && i_addr <= IA_BANK_HI) begin
      o_rd_kind = K_CORE;
    end else if (i_addr == IA_MODE) begin
      o_rd_kind = K_MODE;
    end else if (i_addr == IA_RXSA) begin
      o_rd_kind = K_RXSA;
    end else if (i_addr == IA_NOTE) begin
      o_rd_kind = i_reset_mode ? K_NONE : K_CORE;
    end else if (i_addr >= IA_STAT && i_addr <= IA_TXEC) begin
      o_rd_kind = K_CORE;
    end
  end

  // =====================================================================
  // Write map; read-only and reserved locations fall to K_NONE
  always_comb begin
    o_wr_kind = K_NONE;
    if (i_addr >= IA_FIFO_LO) begin
      o_wr_kind = K_FIFO;
    end else if (i_addr >= IA_TXB_LO && i_addr <= IA_TXB_HI) begin
      o_wr_kind = K_TXB;
    end else if (i_addr >= IA_RXW_LO && i_addr <= IA_RXW_HI) begin
      o_wr_kind = i_reset_mode ? K_RXWIN : K_NONE;
    end else if (i_addr >= IA_ACFE && i_addr <= IA_BANK_HI) begin
      o_wr_kind = K_CORE;
    end else if (i_addr == IA_MODE) begin
      o_wr_kind = K_MODE;
    end else if (i_addr == IA_CMD || i_addr == IA_IEN || i_addr == IA_RXIL || i_addr == IA_EWL) begin
      o_wr_kind = K_CORE;
    end else if (i_addr == IA_BT0 || i_addr == IA_BT1 || i_addr == IA_RXEC || i_addr == IA_TXEC
                 || i_addr == IA_ACFM) begin
      o_wr_kind = i_reset_mode ? K_CORE : K_NONE;
    end
  end
endmodule
`default_nettype wire

// [src/cra_port.sv]
`default_nettype none
module cra_port import cra_pkg::*; (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_rd,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_sfr_ack,
  output logic      [7:0] o_core_addr,
  output logic            o_core_rd,
  output logic            o_core_wr,
  output logic      [7:0] o_core_wdata,
  input  wire logic [7:0] i_core_rdata,
  input  wire logic [5:0] i_rx_start,
  input  wire logic       i_pe_rx_wr,
  input  wire logic [5:0] i_pe_rx_addr,
  input  wire logic [7:0] i_pe_rx_data,
  input  wire logic [3:0] i_pe_tx_idx,
  output logic      [7:0] o_pe_tx_data,
  output logic      [7:0] o_mode
);
  // =====================================================================
  // Storage and pipeline state
  cra_state_t state_r;
  logic [7:0] ptr_r;
  logic [7:0] acc_addr_r;
  logic [7:0] wdata_r;
  logic       acc_rd_r;
  logic       acc_data_r;
  logic       acc_ptr_r;
  cra_kind_t  rkind_r;
  cra_kind_t  wkind_r;
  cra_kind_t  rkind_nxt;
  cra_kind_t  wkind_nxt;
  logic [7:0] iaddr_nxt;
  logic [7:0] rd_mux;
  logic       req;
  logic       req_ptr;
  logic [7:0] transmit_buffer  [0:TXB_LEN-1];
  logic [7:0] fifo [0:FIFO_LEN-1];

  function automatic logic [5:0] win_idx(input logic [7:0] a, input logic [5:0] start);
    logic [7:0] off;
    off = a - IA_RXW_LO;
    return start + off[5:0];
  endfunction

  function automatic logic [3:0] txb_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - IA_TXB_LO;
    return off[3:0];
  endfunction

  // =====================================================================
  // Request acceptance; strobes outside idle are ignored, read beats write
  assign req     = (state_r == ST_IDLE) && (i_sfr_rd || i_sfr_wr)
                   && (i_sfr_addr >= SFR_STA) && (i_sfr_addr <= SFR_MOD);
  assign req_ptr = (i_sfr_addr == SFR_PTR);

  always_comb begin
    unique case (i_sfr_addr)
      SFR_STA: iaddr_nxt = i_sfr_rd ? IA_STAT : IA_IEN;
      SFR_CON: iaddr_nxt = i_sfr_rd ? IA_IRQ : IA_CMD;
      SFR_MOD: iaddr_nxt = IA_MODE;
      default: iaddr_nxt = ptr_r;
    endcase
  end

  cra_decode u_decode (
    .i_addr       (iaddr_nxt),
    .i_reset_mode (o_mode[MODE_RM]),
    .o_rd_kind    (rkind_nxt),
    .o_wr_kind    (wkind_nxt)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE:   state_r <= req ? ST_ACCESS : ST_IDLE;
        ST_ACCESS: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_addr_r <= ZERO8;
      wdata_r    <= ZERO8;
      acc_rd_r   <= 1'b0;
      acc_data_r <= 1'b0;
      acc_ptr_r  <= 1'b0;
      rkind_r    <= K_NONE;
      wkind_r    <= K_NONE;
    end else if (req) begin
      acc_addr_r <= iaddr_nxt;
      wdata_r    <= i_sfr_wdata;
      acc_rd_r   <= i_sfr_rd;
      acc_data_r <= (i_sfr_addr == SFR_DAT);
      acc_ptr_r  <= req_ptr;
      rkind_r    <= req_ptr ? K_NONE : rkind_nxt;
      wkind_r    <= req_ptr ? K_NONE : wkind_nxt;
    end
  end

  // =====================================================================
  // Controller register strobes, one cycle wide
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_addr  <= ZERO8;
      o_core_rd    <= 1'b0;
      o_core_wr    <= 1'b0;
      o_core_wdata <= ZERO8;
    end else begin
      o_core_rd <= req && i_sfr_rd && !req_ptr && (rkind_nxt == K_CORE);
      o_core_wr <= req && !i_sfr_rd && !req_ptr && (wkind_nxt == K_CORE);
      if (req) begin
        o_core_addr  <= iaddr_nxt;
        o_core_wdata <= i_sfr_wdata;
      end
    end
  end

  // =====================================================================
  // Read data and acknowledge
  always_comb begin
    rd_mux = ZERO8;
    if (acc_ptr_r) begin
      rd_mux = ptr_r;
    end else begin
      unique case (rkind_r)
        K_CORE:  rd_mux = i_core_rdata;
        K_MODE:  rd_mux = o_mode;
        K_RXSA:  rd_mux = {2'b00, i_rx_start};
        K_RXWIN: rd_mux = fifo[win_idx(acc_addr_r, i_rx_start)];
        K_TXB:   rd_mux = transmit_buffer[txb_idx(acc_addr_r)];
        K_FIFO:  rd_mux = fifo[acc_addr_r[5:0]];
        K_NONE:  rd_mux = ZERO8;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= ZERO8;
      o_sfr_ack   <= 1'b0;
    end else begin
      o_sfr_ack <= (state_r == ST_ACCESS);
      if (state_r == ST_ACCESS && acc_rd_r) begin
        o_sfr_rdata <= rd_mux;
      end
    end
  end

  // =====================================================================
  // Pointer: written directly, or stepped after a data-port access when it is at AINC_MIN or above
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_r <= ZERO8;
    end else if (state_r == ST_ACCESS) begin
      if (acc_ptr_r && !acc_rd_r) begin
        ptr_r <= wdata_r;
      end else if (acc_data_r && ptr_r >= AINC_MIN) begin
        ptr_r <= ptr_r + 8'h01;
      end
    end
  end

  // =====================================================================
  // Local registers and memories
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode <= MODE_RST;
    end else if (state_r == ST_ACCESS && !acc_rd_r && wkind_r == K_MODE) begin
      o_mode <= wdata_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (state_r == ST_ACCESS && !acc_rd_r && wkind_r == K_TXB) begin
      transmit_buffer[txb_idx(acc_addr_r)] <= wdata_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pe_tx_data <= ZERO8;
    end else begin
      o_pe_tx_data <= (i_pe_tx_idx < TXB_LEN) ? transmit_buffer[i_pe_tx_idx] : ZERO8;
    end
  end

  // Frame reception must never stall, so the engine wins a same-cycle clash
  always_ff @(posedge i_clk) begin
    if (i_pe_rx_wr) begin
      fifo[i_pe_rx_addr] <= i_pe_rx_data;
    end else if (state_r == ST_ACCESS && !acc_rd_r && wkind_r == K_FIFO) begin
      fifo[acc_addr_r[5:0]] <= wdata_r;
    end else if (state_r == ST_ACCESS && !acc_rd_r && wkind_r == K_RXWIN) begin
      fifo[win_idx(acc_addr_r, i_rx_start)] <= wdata_r;
    end
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_take(logic [7:0] a, logic rd);
    req && i_sfr_addr == a && i_sfr_rd == rd;
  endsequence

  property p_inc;
    (state_r == ST_ACCESS && acc_data_r && ptr_r >= AINC_MIN) |=> ptr_r == $past(ptr_r) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer did not step");

  property p_wrap;
    (state_r == ST_ACCESS && acc_data_r && ptr_r == 8'hFF) |=> ptr_r == ZERO8;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_hold;
    (state_r == ST_ACCESS && acc_data_r && ptr_r < AINC_MIN) |=> $stable(ptr_r);
  endproperty
  a_hold: assert property (p_hold) else $error("low pointer moved");

  property p_old_addr;
    s_take(SFR_DAT, 1'b1) or s_take(SFR_DAT, 1'b0) |=> acc_addr_r == $past(ptr_r) ##1 o_sfr_ack;
  endproperty
  a_old_addr: assert property (p_old_addr) else $error("access used stepped address");

  property p_mode_rd;
    s_take(SFR_MOD, 1'b1) |=> ##1 o_sfr_ack && o_sfr_rdata == o_mode;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read mismatch");

  property p_sta_wr;
    s_take(SFR_STA, 1'b0) |=> o_core_wr && o_core_addr == IA_IEN && o_core_wdata == $past(i_sfr_wdata);
  endproperty
  a_sta_wr: assert property (p_sta_wr) else $error("enable write misrouted");

  property p_con_rd;
    s_take(SFR_CON, 1'b1) |=> o_core_rd && o_core_addr == IA_IRQ ##1 o_sfr_ack && !o_core_rd;
  endproperty
  a_con_rd: assert property (p_con_rd) else $error("irq read misrouted");

  property p_rxsa_ro;
    (state_r == ST_ACCESS && acc_addr_r == IA_RXSA && !acc_ptr_r) |-> !o_core_wr;
  endproperty
  a_rxsa_ro: assert property (p_rxsa_ro) else $error("start address written");

  property p_zero;
    (state_r == ST_ACCESS && acc_rd_r && !acc_ptr_r && rkind_r == K_NONE) |=> o_sfr_rdata == ZERO8;
  endproperty
  a_zero: assert property (p_zero) else $error("reserved read not zero");
endmodule
`default_nettype wire

// [testbench/cra_core_model.sv]
`default_nettype none
module cra_core_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_rd,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] last;
  // ==================================================================
  // Controller core registers
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i * 3 + 1);
    end
    last = 8'h00;
  end
  // Outside a read strobe the bus shows inverted stale data, so a late sample cannot match
  assign o_rdata = i_rd ? mem[i_addr] : ~last;
  always @(posedge i_clk) begin
    if (i_rd) begin
      last <= mem[i_addr];
    end
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`default_nettype none
module testbench import cra_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, rd, wr, ack, core_rd, core_wr, pe_wr, rk;
  logic [7:0] addr, wdata, rdata, core_addr, core_wdata, core_rdata;
  logic [7:0] pe_data, tx_data, mode, rq, v;
  logic [5:0] rx_start, pe_addr;
  logic [3:0] tx_idx;
  logic [7:0] fifo [64];
  logic [7:0] txq [$];
  int         error_cnt, compares, ptr, cyc;

  cra_port dut (.i_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_rd(rd), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_ack(ack), .o_core_addr(core_addr),
    .o_core_rd(core_rd), .o_core_wr(core_wr), .o_core_wdata(core_wdata), .i_core_rdata(core_rdata),
    .i_rx_start(rx_start), .i_pe_rx_wr(pe_wr), .i_pe_rx_addr(pe_addr), .i_pe_rx_data(pe_data),
    .i_pe_tx_idx(tx_idx), .o_pe_tx_data(tx_data), .o_mode(mode));
  cra_core_model core_m (.i_clk(clk), .i_addr(core_addr), .i_rd(core_rd), .i_wr(core_wr),
    .i_wdata(core_wdata), .o_rdata(core_rdata));

  // ==================================================================
  // Checking and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [7:0] ini(input int i);
    return 8'(i * 3 + 1);
  endfunction

  // ==================================================================
  // SFR access: one-cycle strobe, wait for the acknowledge pulse
  task automatic acc(input logic [7:0] a, input logic r, input logic [7:0] d);
    int n;
    @(posedge clk);
    addr  <= a;
    rd    <= r;
    wr    <= ~r;
    wdata <= d;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    n  = 0;
    rk = 1'b0;
    while (n < 4 && rk !== 1'b1) begin
      @(negedge clk);
      rk = ack;
      n++;
    end
    rq = rdata;
    chk({7'h00, rk}, {7'h00, a inside {[SFR_STA:SFR_MOD]}});
    if (a == SFR_PTR && !r) begin
      ptr = d;
    end
    if (a == SFR_DAT && ptr >= 32) begin
      ptr = (ptr + 1) % 256;
    end
  endtask
  task automatic rd_at(input logic [7:0] a);
    acc(SFR_PTR, 1'b0, a);
    acc(SFR_DAT, 1'b1, 8'h00);
  endtask
  task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
    acc(SFR_PTR, 1'b0, a);
    acc(SFR_DAT, 1'b0, d);
  endtask
  task automatic chk_ptr();
    acc(SFR_PTR, 1'b1, 8'h00);
    chk(rq, 8'(ptr));
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ==================================================================
  // Main sequence
  initial begin
    {rst_n, rd, wr, pe_wr, addr, wdata, pe_data, pe_addr, rx_start, tx_idx} = '0;
    error_cnt = 0;
    compares  = 0;
    ptr       = 0;
    cyc       = 0;
    void'($urandom(44));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(mode, MODE_RST);
    chk_ptr();
    acc(8'hC5, 1'b1, 8'h00);
    acc(8'hBF, 1'b0, 8'h5A);
    // Direct windows, each direction to its own register
    v = 8'($urandom);
    acc(SFR_STA, 1'b0, v);
    chk(core_m.mem[IA_IEN], v);
    acc(SFR_CON, 1'b0, ~v);
    chk(core_m.mem[IA_CMD], ~v);
    acc(SFR_STA, 1'b1, 8'h00);
    chk(rq, ini(2));
    acc(SFR_CON, 1'b1, 8'h00);
    chk(rq, ini(3));
    // Bus timing is writable only in reset mode; low pointer must not move
    wr_at(IA_BT0, v);
    chk(core_m.mem[IA_BT0], v);
    acc(SFR_MOD, 1'b0, 8'h00);
    chk(mode, 8'h00);
    acc(SFR_MOD, 1'b1, 8'h00);
    chk(rq, 8'h00);
    acc(SFR_DAT, 1'b0, ~v);
    chk(core_m.mem[IA_BT0], v);
    chk_ptr();
    acc(SFR_DAT, 1'b1, 8'h00);
    chk(rq, v);
    rd_at(IA_NOTE);
    chk(rq, ini(8));
    // Receive start is read-only; reserved places read as zero
    rx_start <= 6'($urandom);
    rd_at(IA_RXSA);
    chk(rq, {2'b00, rx_start});
    acc(SFR_DAT, 1'b0, 8'hFF);
    acc(SFR_DAT, 1'b1, 8'h00);
    chk(rq, {2'b00, rx_start});
    rd_at(8'h10);
    chk(rq, 8'h00);
    rd_at(8'h6D);
    chk(rq, 8'h00);
    chk_ptr();
    // Transmit message load by streaming from the first buffer address
    acc(SFR_PTR, 1'b0, IA_TXB_LO);
    for (int i = 0; i < 13; i++) begin
      txq.push_back(8'($urandom));
      acc(SFR_DAT, 1'b0, txq[i]);
    end
    chk_ptr();
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      tx_idx <= 4'(i);
      @(posedge clk);
      @(negedge clk);
      chk(tx_data, txq[i]);
    end
    acc(SFR_PTR, 1'b0, IA_TXB_LO);
    for (int i = 0; i < 13; i++) begin
      acc(SFR_DAT, 1'b1, 8'h00);
      chk(rq, txq[i]);
    end
    // Engine fills the receive FIFO, the CPU reads it several ways
    for (int i = 0; i < 64; i++) begin
      fifo[i] = 8'($urandom);
      @(posedge clk);
      pe_wr   <= 1'b1;
      pe_addr <= 6'(i);
      pe_data <= fifo[i];
    end
    @(posedge clk);
    pe_wr <= 1'b0;
    acc(SFR_PTR, 1'b0, IA_RXW_LO);
    for (int k = 0; k < 13; k++) begin
      acc(SFR_DAT, 1'b1, 8'h00);
      chk(rq, fifo[(int'(rx_start) + k) % 64]);
    end
    for (int k = 0; k < 6; k++) begin
      v = 8'($urandom_range(128, 254));
      rd_at(v);
      chk(rq, fifo[v % 64]);
    end
    wr_at(8'hC5, 8'h3C);
    rd_at(8'h85);
    chk(rq, 8'h3C);
    rd_at(8'hFF);
    chk(rq, fifo[63]);
    chk_ptr();
    // Back in reset mode: location 8 hides, the receive window takes writes
    acc(SFR_MOD, 1'b0, MODE_RST);
    rd_at(IA_NOTE);
    chk(rq, 8'h00);
    wr_at(IA_RXW_LO, 8'hA5);
    rd_at({2'b10, rx_start});
    chk(rq, 8'hA5);
    complete_run();
  end
endmodule
`default_nettype wire
